// ==== mcc_codec_regs.vh ====
// Purpose: Constants for the serial Manchester codec.
// Assumes: One 20 MHz clock; each half bit cell is one clock cycle.
// Notes:   Times are in ns; the cycle counts are derived from them.
`ifndef MCC_CODEC_REGS_VH
`define MCC_CODEC_REGS_VH

// Clock period of the reference clock.
`define MCC_CLK_NS          50
// Narrowest pulse that the line filters accept.
`define MCC_GLITCH_NS       30
// Least time rounds up, and never below one cycle.
`define MCC_GLITCH_CYC      ((`MCC_GLITCH_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
// Quiet time on the receive pair that ends carrier sense.
`define MCC_CARR_HOLD_NS    200
`define MCC_CARR_HOLD_CYC   (`MCC_CARR_HOLD_NS / `MCC_CLK_NS)
// Time the collision output is stretched after the last edge.
`define MCC_COL_STRETCH_NS  400
`define MCC_COL_STRETCH_CYC (`MCC_COL_STRETCH_NS / `MCC_CLK_NS)
// Transmit buffer shape.
`define MCC_FIFO_WIDTH      1
`define MCC_FIFO_DEPTH      8
// Idle select: value of the mode input that picks half step.
`define MCC_IDLE_HALF_STEP  1'h1

`endif

// ==== mcc_codec.v ====
// Purpose: Manchester encoder, decoder, carrier sense and collision logic.
// Assumes: All inputs synchronous to ref_clk_i; differential pairs come
//          in as two logic levels each.
// Notes:   Notes on behaviour follow.
`include "mcc_codec_regs.vh"

// Synchronous FIFO with valid and ready on both sides.
module mcc_fifo #(
    parameter WIDTH = `MCC_FIFO_WIDTH,
    parameter DEPTH = `MCC_FIFO_DEPTH,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             in_valid_i,
    input  wire [WIDTH-1:0] in_data_i,
    output reg              in_ready_o,
    output reg              out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    reg [AW:0]      next_count;

    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];

    // Next fill level from the push and pop of this cycle.
    always @*
    begin
        next_count = count;
        if (push & ~pop)
            next_count = count + {{AW{1'b0}}, 1'b1};
        else if (pop & ~push)
            next_count = count - {{AW{1'b0}}, 1'b1};
    end

    // Pointers, storage and the registered full and empty flags.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr      <= {AW{1'b0}};
            rd_ptr      <= {AW{1'b0}};
            count       <= {(AW+1){1'b0}};
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            count       <= next_count;
            in_ready_o  <= (next_count != DEPTH);
            out_valid_o <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule

// Line filter: a new level is accepted only after it held for HOLD samples.
module mcc_deglitch #(
    parameter HOLD = `MCC_GLITCH_CYC
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire raw_i,
    output reg  level_o
);
    reg [3:0] run;

    // Count how long the raw level differs from the accepted one.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run     <= 4'h0;
            level_o <= 1'b0;
        end
        else if (raw_i == level_o)
            run <= 4'h0;
        else if (run + 4'h1 >= HOLD)
        begin
            level_o <= raw_i;
            run     <= 4'h0;
        end
        else
            run <= run + 4'h1;
    end
endmodule

// Codec top: encoder, decoder, carrier sense and collision detect.
module mcc_codec #(
    parameter CARR_HOLD   = `MCC_CARR_HOLD_CYC,
    parameter COL_STRETCH = `MCC_COL_STRETCH_CYC
) (
    input  wire ref_clk_i,
    input  wire rst_i,
    input  wire tx_valid_i,
    input  wire tx_data_i,
    output wire tx_ready_o,
    output reg  tx_bit_clock_o,
    output reg  tx_pos_o,
    output reg  tx_neg_o,
    input  wire rx_pos_i,
    input  wire rx_neg_i,
    output reg  rx_data_o,
    output reg  recovered_rx_clock_o,
    output reg  carrier_sense_out_o,
    input  wire collision_in_pair_pos_i,
    input  wire collision_in_pair_neg_i,
    output reg  collision_o,
    input  wire loopback_select_i,
    input  wire idle_mode_i
);
    // Differential level: one when the positive leg is above the negative.
    function diff_level;
        input p;
        input n;
        begin
            diff_level = p & ~n;
        end
    endfunction

    wire       fifo_valid;
    wire       fifo_data;
    wire       fifo_pop;
    reg        tx_busy;
    reg        tx_bit;
    reg        next_pos;
    reg        next_neg;
    reg        enc_line;
    wire       raw_rx;
    wire       rx_line;
    wire       col_line;
    reg        rx_prev;
    reg        rx_phase;
    reg        rx_half1;
    reg [3:0]  quiet;
    reg        col_prev;
    reg [3:0]  stretch;

    // Transmit buffer; the controller stalls on tx_ready_o when it fills.
    mcc_fifo #(
        .WIDTH (`MCC_FIFO_WIDTH),
        .DEPTH (`MCC_FIFO_DEPTH),
        .AW    (3)
    ) u_txq (
        .clk_i       (ref_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_data_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    // A bit is taken at the start of each cell, when the bit clock is low.
    assign fifo_pop = ~tx_bit_clock_o & fifo_valid;

    // Encoder: pick the next pair levels for the coming half cell.
    always @*
    begin
        next_pos = 1'b0;
        next_neg = 1'b0;
        enc_line = 1'b0;
        if (~tx_bit_clock_o & fifo_valid)
        begin
            enc_line = ~fifo_data;
            next_pos = ~fifo_data;
            next_neg = fifo_data;
        end
        else if (tx_bit_clock_o & tx_busy)
        begin
            enc_line = tx_bit;
            next_pos = tx_bit;
            next_neg = ~tx_bit;
        end
        else if (idle_mode_i != `MCC_IDLE_HALF_STEP)
        begin
            next_pos = 1'b1;
            next_neg = 1'b0;
        end
        // Half step idle leaves both legs low, which is differential zero.
    end

    // Transmit state, bit clock divider and the pair outputs.
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            tx_bit_clock_o <= 1'b0;
            tx_busy        <= 1'b0;
            tx_bit         <= 1'b0;
            tx_pos_o       <= 1'b0;
            tx_neg_o       <= 1'b0;
        end
        else
        begin
            tx_bit_clock_o <= ~tx_bit_clock_o;
            if (~tx_bit_clock_o)
            begin
                tx_busy <= fifo_valid;
                tx_bit  <= fifo_data;
            end
            // The network pair is held with both legs low while looped back.
            if (loopback_select_i)
            begin
                tx_pos_o <= 1'b0;
                tx_neg_o <= 1'b0;
            end
            else
            begin
                tx_pos_o <= next_pos;
                tx_neg_o <= next_neg;
            end
        end
    end

    // Decoder input: the encoder in loopback, else the receive pair.
    assign raw_rx = loopback_select_i ? enc_line
                                      : diff_level(rx_pos_i, rx_neg_i);

    mcc_deglitch #(
        .HOLD (`MCC_GLITCH_CYC)
    ) u_rx_filt (
        .clk_i   (ref_clk_i),
        .rst_i   (rst_i),
        .raw_i   (raw_rx),
        .level_o (rx_line)
    );

    mcc_deglitch #(
        .HOLD (`MCC_GLITCH_CYC)
    ) u_col_filt (
        .clk_i   (ref_clk_i),
        .rst_i   (rst_i),
        .raw_i   (diff_level(collision_in_pair_pos_i, collision_in_pair_neg_i)),
        .level_o (col_line)
    );

    // Decoder: two samples per cell; equal halves mean we are a half off.
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rx_prev              <= 1'b0;
            rx_phase             <= 1'b0;
            rx_half1             <= 1'b0;
            quiet                <= 4'h0;
            rx_data_o            <= 1'b0;
            recovered_rx_clock_o <= 1'b0;
            carrier_sense_out_o  <= 1'b0;
        end
        else
        begin
            rx_prev <= rx_line;
            // Carrier stays up while edges keep arriving.
            if (rx_line != rx_prev)
            begin
                quiet               <= 4'h0;
                carrier_sense_out_o <= 1'b1;
            end
            else if (quiet + 4'h1 >= CARR_HOLD)
                carrier_sense_out_o <= 1'b0;
            else
                quiet <= quiet + 4'h1;
            if (~carrier_sense_out_o & (rx_line == rx_prev))
                rx_phase <= 1'b0;
            else if (~rx_phase)
            begin
                rx_half1 <= rx_line;
                rx_phase <= 1'b1;
            end
            else if (rx_half1 != rx_line)
            begin
                rx_data_o <= rx_line;
                rx_phase  <= 1'b0;
            end
            else
                rx_half1 <= rx_line;
            recovered_rx_clock_o <= rx_phase;
        end
    end

    // Collision: each edge of the 10 MHz tone reloads the stretcher.
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            col_prev    <= 1'b0;
            stretch     <= 4'h0;
            collision_o <= 1'b0;
        end
        else
        begin
            col_prev <= col_line;
            if (col_line != col_prev)
            begin
                stretch     <= COL_STRETCH[3:0];
                collision_o <= 1'b1;
            end
            else if (stretch != 4'h0)
            begin
                stretch     <= stretch - 4'h1;
                collision_o <= (stretch != 4'h1);
            end
            else
                collision_o <= 1'b0;
        end
    end
endmodule

// ==== mcc_codec_sva.sv ====
// Purpose: Port assertions for the codec.
// Assumes: One clock, synchronous active high reset.
// Notes:   Attached by the bind at the foot.
module mcc_codec_sva #(
    parameter CARR_HOLD   = 4,
    parameter COL_STRETCH = 8
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire tx_bit_clock_o,
    input wire tx_pos_o,
    input wire tx_neg_o,
    input wire rx_pos_i,
    input wire rx_neg_i,
    input wire carrier_sense_out_o,
    input wire collision_in_pair_pos_i,
    input wire collision_o,
    input wire loopback_select_i,
    input wire idle_mode_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] col_quiet;
    // Counts cycles since the positive collision leg last moved.
    always @(posedge ref_clk_i)
        if (rst_i || $changed(collision_in_pair_pos_i))
            col_quiet <= 5'h0;
        else if (col_quiet != 5'h1f)
            col_quiet <= col_quiet + 5'h1;
    sequence s_rx_edge;
        !loopback_select_i && $changed(rx_pos_i);
    endsequence
    sequence s_half1;
        idle_mode_i && tx_bit_clock_o && (tx_pos_o != tx_neg_o);
    endsequence
    a_bit_clock_div: assert property (!$past(rst_i) |->
        tx_bit_clock_o != $past(tx_bit_clock_o)) else $error("bit clock stuck");
    a_cell_second_half: assert property (s_half1 |=>
        tx_pos_o == $past(tx_neg_o) && tx_neg_o == $past(tx_pos_o)) else $error("bad half");
    a_loop_quiet: assert property (loopback_select_i |=>
        !tx_pos_o && !tx_neg_o) else $error("tx pair active in loopback");
    a_full_step_idle: assert property (!$past(idle_mode_i) && !$past(rst_i)
        && !$past(loopback_select_i) |-> tx_pos_o != tx_neg_o) else $error("full step zero");
    a_carr_rise: assert property (s_rx_edge |-> ##[1:3] carrier_sense_out_o)
        else $error("carrier missed");
    a_carr_fall: assert property ((!loopback_select_i && $stable(rx_pos_i)
        && $stable(rx_neg_i)) [*8] |=> !carrier_sense_out_o) else $error("carrier stuck");
    a_col_rise: assert property ($changed(collision_in_pair_pos_i)
        |-> ##[1:3] collision_o) else $error("collision missed");
    a_col_drop: assert property (col_quiet == COL_STRETCH + 4
        |-> !collision_o) else $error("collision overstretched");
endmodule

bind mcc_codec mcc_codec_sva #(.CARR_HOLD(CARR_HOLD), .COL_STRETCH(COL_STRETCH)) i_sva (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .tx_bit_clock_o(tx_bit_clock_o),
    .tx_pos_o(tx_pos_o), .tx_neg_o(tx_neg_o), .rx_pos_i(rx_pos_i), .rx_neg_i(rx_neg_i),
    .carrier_sense_out_o(carrier_sense_out_o), .collision_o(collision_o),
    .collision_in_pair_pos_i(collision_in_pair_pos_i),
    .loopback_select_i(loopback_select_i), .idle_mode_i(idle_mode_i)
);

// ==== mcc_xcvr_model.sv ====
// Purpose: Transceiver model on the receive and collision pairs.
// Assumes: One half cell per clock cycle.
// Notes:   Idle pairs rest at differential zero.
module mcc_xcvr_model (
    input  wire  clk_i,
    input  wire  col_en_i,
    output logic rx_pos_o,
    output logic rx_neg_o,
    output logic col_pos_o,
    output logic col_neg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both pairs start idle.
    initial
    begin
        rx_pos_o = 1'b0;
        rx_neg_o = 1'b0;
        col_pos_o = 1'b0;
        col_neg_o = 1'b0;
    end
    // Sends cells complement first, then true, high bit first.
    task automatic send(logic [15:0] w);
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clk_i);
            #5 {rx_pos_o, rx_neg_o} = {~w[i], w[i]};
            @(posedge clk_i);
            #5 {rx_pos_o, rx_neg_o} = {w[i], ~w[i]};
        end
        @(posedge clk_i);
        #5 {rx_pos_o, rx_neg_o} = 2'h0;
    endtask
    // A toggle every cycle gives a 10 MHz collision signal; updating on the
    // edge itself keeps the enable from racing the bench's own input delay.
    always @(posedge clk_i)
    begin
        col_pos_o <= col_en_i & ~col_pos_o;
        col_neg_o <= col_en_i & col_pos_o;
    end
endmodule

// ==== mcc_codec_tb_top.sv ====
// Purpose: Self-checking bench for the Manchester codec.
// Assumes: 20 MHz clock, transceiver model on the line.
// Notes:   Inputs change 5 ns after each rising edge.
module mcc_codec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic rst = 1;
    logic tv = 0;
    logic td = 0;
    logic lb = 0;
    logic idle = 1;
    logic col_en = 0;
    wire  rdy, bck, tp, tn, rp, rn, rd, rck, carr, cp, cn, col;
    int   err_total = 0;
    int   compares = 0;
    int   cyc = 0;
    mcc_codec #(.CARR_HOLD(4), .COL_STRETCH(8)) i_dut (
        .ref_clk_i(clk), .rst_i(rst), .tx_valid_i(tv), .tx_data_i(td), .tx_ready_o(rdy),
        .tx_bit_clock_o(bck), .tx_pos_o(tp), .tx_neg_o(tn), .rx_pos_i(rp), .rx_neg_i(rn),
        .rx_data_o(rd), .recovered_rx_clock_o(rck), .carrier_sense_out_o(carr),
        .collision_in_pair_pos_i(cp), .collision_in_pair_neg_i(cn), .collision_o(col),
        .loopback_select_i(lb), .idle_mode_i(idle));
    mcc_xcvr_model i_xcvr (.clk_i(clk), .col_en_i(col_en), .rx_pos_o(rp),
        .rx_neg_o(rn), .col_pos_o(cp), .col_neg_o(cn));
    // The 20 MHz reference clock.
    initial
        forever #25 clk = ~clk;
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        compares++;
        if (e !== g)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    // Holds each bit until the buffer takes it.
    task automatic push(logic [23:0] pat, output int refused);
        refused = 0;
        for (int i = 23; i >= 0; i--)
        begin
            tv = 1;
            td = pat[i];
            while (rdy !== 1'b1)
            begin
                refused++;
                step(1);
            end
            step(1);
        end
        tv = 0;
    endtask
    // Reads each first half cell off the pair.
    task automatic get_tx(output logic [23:0] got);
        for (int i = 23; i >= 0; i--)
        begin
            int n = 0;
            while (!(bck === 1'b1 && tp !== tn) && n < 40)
            begin
                step(1);
                n++;
            end
            got[i] = tn;
            step(1);
        end
    endtask
    // Shifts in a bit at each fall of the receive clock and looks for b.
    task automatic cap_rx(int n, logic [7:0] b, output logic hit);
        logic [7:0] sh = 8'h0;
        logic       pr = 1'b0;
        hit = 1'b0;
        repeat (n)
        begin
            step(1);
            if (pr === 1'b1 && rck === 1'b0)
                sh = {sh[6:0], rd};
            hit |= (sh === b);
            pr = rck;
        end
    endtask
    task automatic t_tx();
        int         ref_n;
        logic [23:0] got;
        fork
            push(24'h96c3a5, ref_n);
            get_tx(got);
        join
        chk("tx_bits", 24'h96c3a5, got);
        chk("tx_refused", 1, ref_n > 0);
        step(3);
        chk("tx_idle_half", 0, {tp, tn});
        chk("tx_ready", 1, rdy);
    endtask
    task automatic t_full();
        logic b;
        idle = 0;
        step(3);
        chk("tx_idle_full", 2'h2, {tp, tn});
        b = bck;
        idle = 1;
        step(1);
        chk("tx_bit_clock", !b, bck);
        step(2);
        chk("tx_idle_sel", 0, {tp, tn});
    endtask
    task automatic t_rx();
        logic hit;
        fork
            i_xcvr.send(16'h55c6);
            cap_rx(50, 8'hc6, hit);
            begin
                step(20);
                chk("carr_busy", 1, carr);
            end
        join
        chk("rx_byte", 1, hit);
        chk("carr_idle", 0, carr);
    endtask
    task automatic t_loop();
        int   ref_n;
        logic hit;
        lb = 1;
        fork
            push(24'h0055c6, ref_n);
            cap_rx(70, 8'hc6, hit);
        join
        chk("loop_byte", 1, hit);
        chk("loop_pair", 0, {tp, tn});
        lb = 0;
        step(10);
    endtask
    task automatic t_col();
        col_en = 1;
        step(4);
        chk("col_on", 1, col);
        col_en = 0;
        step(4);
        chk("col_stretch", 1, col);
        step(12);
        chk("col_off", 0, col);
    endtask
    // Reset, then each scenario in turn.
    initial
    begin
        step(20);
        rst = 0;
        t_tx();
        t_full();
        t_rx();
        t_loop();
        t_col();
        print_verdict();
    end
endmodule
